// ### inc/rotc_pkg.sv
// Constants and carrier types for the reset sequencer and oscillator trim block.
// Assumes a single 200 MHz clock and a plain strobe register port.
// ==========================================================================
// What this block does
// RULE_01: Last program word is a load-literal carrying the calibration value, run at reset.
// RULE_02: After the calibration word the fetch address wraps to 0x000.
// RULE_03: Calibration word location is always read-protected, whatever code protection says.
// RULE_04: Oscillator trim at 05h implements only bits 7 to 2.
// RULE_05: Writing the trim value adjusts the internal oscillator frequency.
// RULE_06: Internal RC selected gives a fixed nominal 4 MHz system clock.
// RULE_07: Six reset causes are told apart.
// RULE_08: Some registers are never reset: unknown at power-on, kept otherwise.
// RULE_09: Most registers load reset values on resets during normal operation.
// RULE_10: Watchdog or master-clear reset in sleep leaves those registers alone.
// RULE_11: Timeout, power-down and pin-change flags identify the reset cause.
// RULE_12: Pin-change wake flag reads one only after a pin-change wake reset.
// RULE_13: Enable bit at one makes the shared pin the active-low master-clear.
// RULE_14: Enable bit programmed ties master-clear inactive; pin becomes general I/O.
// RULE_15: Power-on reset holds the chip until the supply is adequate.
// RULE_16: On power-up the latch is set and the reset timer cleared.
// RULE_17: Reset timer counts only while master-clear is seen high.
// RULE_18: After about 18 ms the timer clears the latch and releases reset.
// RULE_19: Master-clear held low at power-up: release one period after it rises.
// RULE_20: External driver holds reset until operating conditions are met.
// RULE_21: Master-clear low again before expiry restarts the timer, reset held.

package rotc_pkg;

  // ========================================================================
  // Register map
  localparam logic [7:0] ROTC_OSC_TRIM_ADDR = 8'h05;
  localparam logic [7:0] ROTC_STATUS_ADDR = 8'h03;
  localparam logic [7:0] ROTC_CAUSE_ADDR = 8'h10;
  localparam logic [7:0] ROTC_CALIB_ADDR = 8'h11;
  localparam logic [7:0] ROTC_PCADDR_ADDR = 8'h12;
  localparam logic [7:0] ROTC_OSC_TRIM_RESET = 8'h80;
  localparam logic [7:0] ROTC_OSC_TRIM_MASK = 8'hFC;
  localparam int ROTC_WAKE_FLAG_BIT = 7;
  localparam int ROTC_TIMEOUT_FLAG_BIT = 4;
  localparam int ROTC_POWER_DOWN_FLAG_BIT = 3;

  // ========================================================================
  // Program memory layout and the load-literal opcode
  localparam int ROTC_PC_WIDTH = 10;
  localparam logic [9:0] ROTC_RESET_VECTOR = 10'h3FF;
  localparam logic [9:0] ROTC_USER_START = 10'h000;
  localparam logic [3:0] ROTC_LOAD_LITERAL_OP = 4'hC;

  // ========================================================================
  // Timing
  localparam int ROTC_CLOCK_HZ = 200_000_000;
  localparam int ROTC_RESET_TIMER_PERIOD_MS = 18;
  localparam longint ROTC_RESET_TIMER_CYCLES =
    longint'(ROTC_CLOCK_HZ) / 1000 * ROTC_RESET_TIMER_PERIOD_MS;
  localparam int ROTC_SYSCLK_HZ = 4_000_000;
  localparam int ROTC_SYSCLK_HALF = ROTC_CLOCK_HZ / ROTC_SYSCLK_HZ / 2;

  typedef enum logic [2:0] {
    ROTC_CAUSE_POWER_ON,
    ROTC_CAUSE_MASTER_CLEAR_PIN_RUN,
    ROTC_CAUSE_MASTER_CLEAR_PIN_SLEEP,
    ROTC_CAUSE_WDT_RUN,
    ROTC_CAUSE_WDT_SLEEP,
    ROTC_CAUSE_PIN_WAKE
  } rotc_cause_t;

  typedef enum logic [1:0] {
    ROTC_ST_HOLD,
    ROTC_ST_COUNT,
    ROTC_ST_RUN
  } rotc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rotc_bus_req_t;

  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic pin_change_wake_flag;
  } rotc_flags_t;

endpackage : rotc_pkg

// ### hw/rotc_top.sv
// Reset sequencer, reset cause flags and oscillator trim register.
// Assumes sleep, watchdog and wake events come from the same clock
// domain; the master-clear pin and supply-good are asynchronous and synchronised.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps

module rotc_top
  import rotc_pkg::*;
#(
  parameter longint RESET_TIMER_CYCLES = ROTC_RESET_TIMER_CYCLES,
  parameter int TIMER_WIDTH = 32
)(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic i_clk_en,
  input wire logic i_supply_ok,
  input wire logic i_master_clear_pin_enable,
  input wire logic i_master_clear_pin_n,
  input wire logic i_watchdog_timeout,
  input wire logic i_pin_change_wake,
  input wire logic i_sleep_enter,
  input wire logic i_clear_watchdog,
  input wire logic i_internal_rc_sel,
  input wire logic [7:0] i_calibration_value,
  input wire logic i_fetch_next,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_chip_reset,
  output logic o_core_reset,
  output logic o_master_clear_is_io,
  output logic [7:0] o_osc_trim,
  output logic o_sysclk,
  output logic [9:0] o_fetch_addr,
  output logic [11:0] o_fetch_word,
  output logic o_calib_read_blocked,
  output logic [2:0] o_reset_cause
);

  // Elaboration check: the timer must be able to hold the full reset count
  if (RESET_TIMER_CYCLES < 1 || RESET_TIMER_CYCLES >= (longint'(1) << TIMER_WIDTH))
  begin : g_bad_timer
    $error("rotc_top: reset timer count does not fit");
  end

  // ========================================================================
  // State
  typedef struct packed {
    logic [1:0] master_clear_pin_sync;
    logic [1:0] supply_sync;
    rotc_state_t state;
    logic [TIMER_WIDTH-1:0] timer;
    logic reset_latch;
    logic asleep;
    logic power_on;
    rotc_cause_t cause;
    rotc_flags_t flags;
    logic [7:0] osc_trim;
    logic [9:0] pc;
    logic [11:0] fetch_word;
    logic [7:0] rdata;
    logic [7:0] div_cnt;
    logic sysclk;
    logic core_reset;
  } rotc_regs_t;

  rotc_regs_t state_reg;
  rotc_regs_t state_next;
  rotc_bus_req_t bus;
  logic master_clear_pin_low;
  logic supply_good;
  logic warm_reset;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input rotc_regs_t s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ROTC_OSC_TRIM_ADDR: v = s.osc_trim & ROTC_OSC_TRIM_MASK;
      ROTC_STATUS_ADDR:
      begin
        v[ROTC_WAKE_FLAG_BIT] = s.flags.pin_change_wake_flag;
        v[ROTC_TIMEOUT_FLAG_BIT] = s.flags.watchdog_timeout_flag;
        v[ROTC_POWER_DOWN_FLAG_BIT] = s.flags.power_down_flag;
      end
      ROTC_CAUSE_ADDR: v = {5'h00, s.cause};
      ROTC_CALIB_ADDR: v = 8'h00; // Calibration word never readable RULE_03
      ROTC_PCADDR_ADDR: v = s.pc[7:0];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // ========================================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    state_next.master_clear_pin_sync = {state_reg.master_clear_pin_sync[0], i_master_clear_pin_n};
    state_next.supply_sync = {state_reg.supply_sync[0], i_supply_ok};
    // Pin ignored as reset when configured as I/O RULE_13 RULE_14
    master_clear_pin_low = i_master_clear_pin_enable & ~state_reg.master_clear_pin_sync[1];
    supply_good = state_reg.supply_sync[1];
    warm_reset = 1'b0;

    // Reset latch and device reset timer
    if (!supply_good)
    begin
      state_next.state = ROTC_ST_HOLD; // RULE_15
      state_next.reset_latch = 1'b1; // RULE_16
      state_next.timer = '0;
      state_next.power_on = 1'b1;
    end
    else
    begin
      case (state_reg.state)
        ROTC_ST_HOLD:
        begin
          state_next.timer = '0;
          if (!master_clear_pin_low)
          begin
            state_next.state = ROTC_ST_COUNT; // RULE_17
          end
        end
        ROTC_ST_COUNT:
        begin
          if (master_clear_pin_low)
          begin
            state_next.state = ROTC_ST_HOLD; // RULE_21
            state_next.timer = '0;
          end
          else if (state_reg.timer == TIMER_WIDTH'(RESET_TIMER_CYCLES - 1))
          begin
            state_next.state = ROTC_ST_RUN; // RULE_18 RULE_19
            state_next.reset_latch = 1'b0;
            state_next.timer = '0;
          end
          else
          begin
            state_next.timer = state_reg.timer + 1'b1;
          end
        end
        ROTC_ST_RUN:
        begin
          if (master_clear_pin_low)
          begin
            state_next.state = ROTC_ST_HOLD; // RULE_21
            state_next.reset_latch = 1'b1;
          end
        end
        default: state_next.state = ROTC_ST_HOLD;
      endcase
    end

    // Cause decode and flag update RULE_07 RULE_11 RULE_12
    if (state_reg.reset_latch && !state_next.reset_latch)
    begin
      warm_reset = 1'b1;
      if (state_reg.power_on)
      begin
        state_next.cause = ROTC_CAUSE_POWER_ON;
        state_next.flags = '{1'b1, 1'b1, 1'b0};
      end
      else if (state_reg.asleep)
      begin
        state_next.cause = ROTC_CAUSE_MASTER_CLEAR_PIN_SLEEP;
        state_next.flags = '{1'b1, 1'b0, 1'b0};
      end
      else
      begin
        state_next.cause = ROTC_CAUSE_MASTER_CLEAR_PIN_RUN;
        state_next.flags.pin_change_wake_flag = 1'b0;
      end
      state_next.power_on = 1'b0;
    end
    else if (!state_reg.reset_latch && !master_clear_pin_low)
    begin
      if (i_watchdog_timeout)
      begin
        warm_reset = 1'b1;
        state_next.cause = state_reg.asleep ? ROTC_CAUSE_WDT_SLEEP : ROTC_CAUSE_WDT_RUN;
        state_next.flags = '{1'b0, ~state_reg.asleep, 1'b0};
      end
      else if (i_pin_change_wake && state_reg.asleep)
      begin
        warm_reset = 1'b1;
        state_next.cause = ROTC_CAUSE_PIN_WAKE;
        state_next.flags = '{1'b1, 1'b0, 1'b1};
      end
      else if (i_sleep_enter)
      begin
        state_next.asleep = 1'b1;
        state_next.flags.watchdog_timeout_flag = 1'b1;
        state_next.flags.power_down_flag = 1'b0;
      end
      else if (i_clear_watchdog)
      begin
        state_next.flags.watchdog_timeout_flag = 1'b1;
        state_next.flags.power_down_flag = 1'b1;
      end
    end

    // Register reset scope RULE_08 RULE_09 RULE_10
    state_next.core_reset = state_next.reset_latch;
    if (warm_reset)
    begin
      state_next.asleep = 1'b0;
      state_next.pc = ROTC_RESET_VECTOR; // RULE_01
      if (!(state_reg.asleep && (state_next.cause == ROTC_CAUSE_WDT_SLEEP ||
                                  state_next.cause == ROTC_CAUSE_MASTER_CLEAR_PIN_SLEEP)))
      begin
        state_next.osc_trim = ROTC_OSC_TRIM_RESET; // RULE_09
      end
    end
    if (state_next.reset_latch)
    begin
      state_next.pc = ROTC_RESET_VECTOR;
    end

    // Fetch stream: calibration word first, then wrap to user start
    state_next.fetch_word = (state_reg.pc == ROTC_RESET_VECTOR) ?
      {ROTC_LOAD_LITERAL_OP, i_calibration_value} : 12'h000; // RULE_01
    if (i_fetch_next && !state_reg.reset_latch && !warm_reset)
    begin
      state_next.pc = (state_reg.pc == ROTC_RESET_VECTOR) ?
        ROTC_USER_START : state_reg.pc + 1'b1; // RULE_02
    end

    // Register port
    if (bus.wr && bus.addr == ROTC_OSC_TRIM_ADDR && !state_reg.reset_latch)
    begin
      state_next.osc_trim = bus.wdata & ROTC_OSC_TRIM_MASK; // RULE_04 RULE_05
    end
    state_next.rdata = bus.rd ? read_mux(bus.addr, state_reg) : 8'h00;

    // Nominal 4 MHz system clock from the internal RC RULE_06
    if (i_internal_rc_sel)
    begin
      if (state_reg.div_cnt == 8'(ROTC_SYSCLK_HALF - 1))
      begin
        state_next.div_cnt = 8'h00;
        state_next.sysclk = ~state_reg.sysclk;
      end
      else
      begin
        state_next.div_cnt = state_reg.div_cnt + 8'h01;
      end
    end
    else
    begin
      state_next.div_cnt = 8'h00;
      state_next.sysclk = 1'b0;
    end
  end

  // ========================================================================
  // Registers. The trim register is a retained store: clocks never erase it
  // except through the reset scope above, which keeps it across watchdog and master-clear resets in sleep.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_reg <= '{master_clear_pin_sync: 2'b00, supply_sync: 2'b00, state: ROTC_ST_HOLD,
                     timer: '0, reset_latch: 1'b1, asleep: 1'b0, power_on: 1'b1,
                     cause: ROTC_CAUSE_POWER_ON, flags: '{1'b1, 1'b1, 1'b0},
                     osc_trim: ROTC_OSC_TRIM_RESET, pc: ROTC_RESET_VECTOR,
                     fetch_word: 12'h000, rdata: 8'h00, div_cnt: 8'h00,
                     sysclk: 1'b0, core_reset: 1'b1}; // RULE_16
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs
  assign o_rdata = state_reg.rdata;
  assign o_chip_reset = state_reg.reset_latch; // RULE_15
  assign o_core_reset = state_reg.core_reset;
  assign o_master_clear_is_io = ~i_master_clear_pin_enable; // RULE_14
  assign o_osc_trim = state_reg.osc_trim;
  assign o_sysclk = state_reg.sysclk;
  assign o_fetch_addr = state_reg.pc;
  assign o_fetch_word = state_reg.fetch_word;
  assign o_calib_read_blocked = 1'b1; // RULE_03
  assign o_reset_cause = state_reg.cause;

endmodule : rotc_top

// ### verif/rotc_master_clear_pin_model.sv
// Partner model: supply monitor and reset switch on the master-clear pin.
// Assumes the bench raises i_press to pull the pin low; the pin has a pull-up.
`timescale 1ns/10ps
module rotc_master_clear_pin_model #(
  parameter int SUPPLY_DELAY = 8,
  parameter int PIN_DELAY = 16
)(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_press,
  output logic o_supply_ok,
  output logic o_pin_n
);
  int cnt_reg;
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      cnt_reg <= 0;
      o_supply_ok <= 1'b0;
      o_pin_n <= 1'b0;
    end
    else
    begin
      if (cnt_reg < PIN_DELAY)
        cnt_reg <= cnt_reg + 1;
      o_supply_ok <= (cnt_reg >= SUPPLY_DELAY);
      // Pin kept low until PIN_DELAY counts, past supply-good at SUPPLY_DELAY, then low only on request
      o_pin_n <= (cnt_reg >= PIN_DELAY) && !i_press;
    end
endmodule : rotc_master_clear_pin_model

// ### verif/rotc_top_sva.sv
// Checker for the reset sequencer and trim register.
// Bound to rotc_top; sees only its ports.
`timescale 1ns/10ps
module rotc_top_sva
  import rotc_pkg::*;
#(
  parameter longint RESET_TIMER_CYCLES = ROTC_RESET_TIMER_CYCLES
)(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic i_clk_en,
  input wire logic i_supply_ok,
  input wire logic i_master_clear_pin_enable,
  input wire logic i_master_clear_pin_n,
  input wire logic [7:0] i_calibration_value,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_chip_reset,
  input wire logic o_master_clear_is_io,
  input wire logic [7:0] o_osc_trim,
  input wire logic [9:0] o_fetch_addr,
  input wire logic [11:0] o_fetch_word
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  // ==========================================================================
  // Helper logic
  logic low_w;
  logic held_reg;
  logic held_next;
  int run_reg;
  int run_next;
  assign low_w = !i_supply_ok || (i_master_clear_pin_enable && !i_master_clear_pin_n);
  // Raw pin is counted, so the sync delay only loosens the bounds
  always_comb
  begin
    held_next = low_w || (held_reg && o_chip_reset);
    run_next = (o_chip_reset && !low_w) ? run_reg + int'(i_clk_en) : 0;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    if (!I_RESET_N)
    begin
      held_reg <= 1'b1;
      run_reg <= 0;
    end
    else
    begin
      held_reg <= held_next;
      run_reg <= run_next;
    end
  // ==========================================================================
  // Properties
  sequence s_pin_low;
    (i_clk_en && i_master_clear_pin_enable && !i_master_clear_pin_n)[*6];
  endsequence
  sequence s_trim_wr;
    i_wr && i_clk_en && !o_chip_reset && i_addr == ROTC_OSC_TRIM_ADDR;
  endsequence
  chk_trim_bits: assert property (o_osc_trim[1:0] == 2'b00)
    else $error("trim low bits set");
  chk_trim_write: assert property (s_trim_wr |=>
    o_osc_trim == ($past(i_wdata) & ROTC_OSC_TRIM_MASK)) else $error("trim write lost");
  chk_pin_select: assert property (o_master_clear_is_io == !i_master_clear_pin_enable)
    else $error("pin select wrong");
  chk_pin_hold: assert property (s_pin_low |-> o_chip_reset)
    else $error("reset released with pin low");
  chk_supply_hold: assert property ((i_clk_en && !i_supply_ok)[*6] |-> o_chip_reset)
    else $error("reset released without supply");
  chk_timer_early: assert property ($fell(o_chip_reset) && held_reg |->
    run_reg >= RESET_TIMER_CYCLES) else $error("reset timer too short");
  chk_timer_late: assert property (run_reg <= RESET_TIMER_CYCLES + 6)
    else $error("reset timer too long");
  chk_fetch_wrap: assert property ($past(o_fetch_addr) == ROTC_RESET_VECTOR &&
    o_fetch_addr != ROTC_RESET_VECTOR |-> o_fetch_addr == ROTC_USER_START)
    else $error("fetch did not wrap");
  chk_cal_word: assert property (o_fetch_word != 12'h000 |->
    o_fetch_word == {ROTC_LOAD_LITERAL_OP, $past(i_calibration_value)})
    else $error("calibration word wrong");
endmodule : rotc_top_sva
bind rotc_top rotc_top_sva #(.RESET_TIMER_CYCLES(RESET_TIMER_CYCLES)) rotc_top_sva_inst (.*);

// ### verif/test_reset_and_osc_trim_control.sv
// Self-checking bench for the reset sequencer and trim register.
// Assumes the partner model drives supply-good and the master-clear pin.
`timescale 1ns/10ps
module test_reset_and_osc_trim_control;
  import rotc_pkg::*;
  localparam int N = 20;
  logic I_CLOCK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_master_clear_pin_enable = 1'b1;
  logic i_watchdog_timeout = 1'b0, i_pin_change_wake = 1'b0, i_sleep_enter = 1'b0;
  logic i_clear_watchdog = 1'b0, i_internal_rc_sel = 1'b1, i_fetch_next = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0, press = 1'b0;
  logic [7:0] i_calibration_value = 8'h00, i_addr = 8'h00, i_wdata = 8'h00;
  logic i_supply_ok, i_master_clear_pin_n;
  logic o_chip_reset, o_core_reset, o_master_clear_is_io, o_sysclk, o_calib_read_blocked;
  logic [7:0] o_rdata, o_osc_trim, mtrim, v;
  logic [9:0] o_fetch_addr;
  logic [11:0] o_fetch_word;
  logic [2:0] o_reset_cause;
  int fails = 0, checked = 0, mto = 1, mpd = 1, mwake = 0, c;
  int tto[6] = '{1, -1, 1, 0, 0, 1};
  int tpd[6] = '{1, -1, 0, 1, 0, 0};
  int order[6] = '{3, 1, 5, 4, 2, 1};
  rotc_top #(.RESET_TIMER_CYCLES(N)) rotc_top_inst (.*);
  rotc_master_clear_pin_model rotc_master_clear_pin_model_inst (.i_clock(I_CLOCK), .i_reset_n(I_RESET_N),
    .i_press(press), .o_supply_ok(i_supply_ok), .o_pin_n(i_master_clear_pin_n));
  initial
  begin
    forever #2.5 I_CLOCK = ~I_CLOCK;
  end
  // ==========================================================================
  // Tasks
  task automatic ck(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : ck
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLOCK);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge I_CLOCK);
    i_wr <= 1'b0;
  endtask : wr_reg
  task automatic rck(input logic [7:0] a, input logic [7:0] e);
    @(posedge I_CLOCK);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge I_CLOCK);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    ck(v & ((a == ROTC_STATUS_ADDR) ? 8'h98 : 8'hFF), e);
  endtask : rck
  // Counts falling edges until the chip leaves reset, capped to catch a hang
  task automatic wait_run(output int n);
    n = 0;
    while (o_chip_reset !== 1'b0 && n < 500)
    begin
      @(negedge I_CLOCK);
      n++;
    end
  endtask : wait_run
  task automatic hit(input int k);
    logic [7:0] r;
    r = 8'($urandom);
    wr_reg(ROTC_OSC_TRIM_ADDR, r);
    mtrim = (k == 2 || k == 4) ? (r & 8'hFC) : 8'h80;
    @(posedge I_CLOCK);
    i_sleep_enter <= (k == 2 || k >= 4);
    @(posedge I_CLOCK);
    i_sleep_enter <= 1'b0;
    i_watchdog_timeout <= (k == 3 || k == 4);
    i_pin_change_wake <= (k == 5);
    press <= (k <= 2);
    @(posedge I_CLOCK);
    i_watchdog_timeout <= 1'b0;
    i_pin_change_wake <= 1'b0;
    repeat (4) @(posedge I_CLOCK);
    press <= 1'b0;
    if (k == 1)
    begin
      repeat (N / 2) @(posedge I_CLOCK);
      press <= 1'b1;
      #1 ck(o_chip_reset, 1'b1);
      ck(o_core_reset, 1'b1);
      repeat (4) @(posedge I_CLOCK);
      press <= 1'b0;
    end
    wait_run(c);
    ck(c < 500, 1'b1);
    if (tto[k] >= 0) mto = tto[k];
    if (tpd[k] >= 0) mpd = tpd[k];
    mwake = (k == 5);
    ck(o_reset_cause, 12'(k));
    rck(ROTC_CAUSE_ADDR, 8'(k));
    rck(ROTC_STATUS_ADDR, {mwake[0], 2'b00, mto[0], mpd[0], 3'b000});
    rck(ROTC_OSC_TRIM_ADDR, mtrim);
    $display("reset event %0d done", k);
  endtask : hit
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Sequence
  initial
  begin
    void'($urandom(51037));
    i_calibration_value <= 8'($urandom);
    repeat (10) @(posedge I_CLOCK);
    I_RESET_N <= 1'b1;
    while (i_master_clear_pin_n !== 1'b1) @(negedge I_CLOCK);
    wait_run(c);
    ck(c >= N && c <= N + 6, 1'b1);
    ck(o_core_reset, 1'b0);
    rck(ROTC_STATUS_ADDR, 8'h18);
    rck(ROTC_CAUSE_ADDR, 8'h00);
    rck(ROTC_OSC_TRIM_ADDR, ROTC_OSC_TRIM_RESET);
    $display("power-on done");
    for (int i = 0; i < 4; i++)
    begin
      mtrim = 8'($urandom);
      wr_reg(ROTC_OSC_TRIM_ADDR, mtrim);
      rck(ROTC_OSC_TRIM_ADDR, mtrim & 8'hFC);
    end
    rck(8'h20, 8'h00);
    rck(ROTC_CALIB_ADDR, 8'h00);
    ck(o_calib_read_blocked, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge I_CLOCK);
      i_fetch_next <= 1'b1;
      @(posedge I_CLOCK);
      i_fetch_next <= 1'b0;
      #1 ck(o_fetch_addr, 10'(i));
      ck(o_fetch_word, (i == 0) ? {4'hC, i_calibration_value} : 12'h000);
    end
    $display("register and fetch done");
    // One half period of the divided clock, toggle to toggle
    @(negedge I_CLOCK);
    v[0] = o_sysclk;
    while (o_sysclk === v[0]) @(negedge I_CLOCK);
    c = 0;
    while (o_sysclk === ~v[0] && c < 100)
    begin
      @(negedge I_CLOCK);
      c++;
    end
    ck(12'(c), 12'(ROTC_SYSCLK_HALF));
    $display("system clock done");
    ck(o_master_clear_is_io, 1'b0);
    @(posedge I_CLOCK);
    i_master_clear_pin_enable <= 1'b0;
    press <= 1'b1;
    repeat (10) @(posedge I_CLOCK);
    #1 ck(o_chip_reset, 1'b0);
    ck(o_master_clear_is_io, 1'b1);
    @(posedge I_CLOCK);
    press <= 1'b0;
    // Pin must be high through both sync stages before it acts as reset again
    repeat (6) @(posedge I_CLOCK);
    i_master_clear_pin_enable <= 1'b1;
    repeat (4) @(posedge I_CLOCK);
    $display("pin select done");
    foreach (order[i]) hit(order[i]);
    @(posedge I_CLOCK);
    i_clear_watchdog <= 1'b1;
    @(posedge I_CLOCK);
    i_clear_watchdog <= 1'b0;
    rck(ROTC_STATUS_ADDR, 8'h18);
    $display("clear watchdog done");
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge I_CLOCK);
    fails++;
    print_verdict();
  end
endmodule : test_reset_and_osc_trim_control
